// File: flsdm_consts.vh
`ifndef FLSDM_CONSTS_VH
`define FLSDM_CONSTS_VH

// ==========================================================
// register byte offsets
`define FLSDM_OFF_REFDIV     8'h00
`define FLSDM_OFF_NDIV       8'h04
`define FLSDM_OFF_CTRL       8'h08
`define FLSDM_OFF_NOISE      8'h0c
`define FLSDM_OFF_STATUS     8'h10
`define FLSDM_OFF_STORED     8'h14

// ==========================================================
// field positions within the 24-bit configuration words
`define FLSDM_LOADCTL_BIT    23
`define FLSDM_MUXSEL_HI      22
`define FLSDM_MUXSEL_LO      20
`define FLSDM_MODFLD_HI      13
`define FLSDM_MODFLD_LO      2
`define FLSDM_FLFLAG_BIT     23
`define FLSDM_FRACFLD_HI     13
`define FLSDM_FRACFLD_LO     2
`define FLSDM_CPCUR_HI       10
`define FLSDM_CPCUR_LO       7
`define FLSDM_NSMODE_HI      3
`define FLSDM_NSMODE_LO      2

// ==========================================================
// codes and limits
`define FLSDM_MUXSEL_FLSW    3'b110
`define FLSDM_NSMODE_SPUR    2'b00
`define FLSDM_MOD_MIN        12'h002
`define FLSDM_CP_BOOST_SH    4
`define FLSDM_RESP_OKAY      2'b00
`define FLSDM_RESP_SLVERR    2'b10

// ==========================================================
// reset values and timing
`define FLSDM_RST_MOD        12'h002
`define FLSDM_RST_WORD       24'h000000
`define FLSDM_PFD_DIV        8'h03
`define FLSDM_LFSR_SEED      21'h000001

`endif

// File: flsdm_sdm.v
`timescale 1ns/10ps
`default_nettype none

// third-order modulus accumulator cascade, one step per comparison tick
module flsdm_sdm #(
	parameter W = 12
) (
	input  wire                aclk,
	input  wire                aresetn,
	input  wire                step_en,
	input  wire [W-1:0]        modulus,
	input  wire [W-1:0]        fraction,
	input  wire                dither_en,
	output reg  signed [3:0]   sdm_out
);

`include "flsdm_consts.vh"

	reg  [W-1:0]  acc1;
	reg  [W-1:0]  acc2;
	reg  [W-1:0]  acc3;
	reg           c2_d;
	reg           c3_d;
	reg           c3_dd;
	reg  [20:0]   lfsr;
	reg  [W-1:0]  mod_q;
	wire          mod_chg;
	wire          dith_bit;
	wire [W:0]    sum1;
	wire [W:0]    sum2;
	wire [W:0]    sum3;
	wire          c1;
	wire          c2;
	wire          c3;
	wire [W-1:0]  next_acc1;
	wire [W-1:0]  next_acc2;
	wire [W-1:0]  next_acc3;
	wire signed [3:0] next_sdm_out;

	// ==========================================================
	// dither source, 21-stage shift register
	assign dith_bit = dither_en & lfsr[0];

	// ==========================================================
	// a new modulus restarts the cascade so no accumulator is left above it
	assign mod_chg = (mod_q != modulus);

	// ==========================================================
	// modulo accumulators
	assign sum1 = {1'b0, acc1} + {1'b0, fraction} + {{W{1'b0}}, dith_bit};
	assign c1 = (sum1 >= {1'b0, modulus});
	assign next_acc1 = c1 ? sum1[W-1:0] - modulus : sum1[W-1:0];
	assign sum2 = {1'b0, acc2} + {1'b0, next_acc1};
	assign c2 = (sum2 >= {1'b0, modulus});
	assign next_acc2 = c2 ? sum2[W-1:0] - modulus : sum2[W-1:0];
	assign sum3 = {1'b0, acc3} + {1'b0, next_acc2};
	assign c3 = (sum3 >= {1'b0, modulus});
	assign next_acc3 = c3 ? sum3[W-1:0] - modulus : sum3[W-1:0];

	// noise-shaping combiner: c1 + (1-z^-1)c2 + (1-z^-1)^2 c3
	assign next_sdm_out = $signed({3'b000, c1}) + $signed({3'b000, c2}) - $signed({3'b000, c2_d})
		+ $signed({3'b000, c3}) - $signed({2'b00, c3_d, 1'b0}) + $signed({3'b000, c3_dd});

	always @(posedge aclk) begin
		if (!aresetn) begin
			acc1    <= {W{1'b0}};
			acc2    <= {W{1'b0}};
			acc3    <= {W{1'b0}};
			c2_d    <= 1'b0;
			c3_d    <= 1'b0;
			c3_dd   <= 1'b0;
			lfsr    <= `FLSDM_LFSR_SEED;
			sdm_out <= 4'sh0;
			mod_q   <= {W{1'b0}};
		end else if (mod_chg) begin
			mod_q   <= modulus;
			acc1    <= {W{1'b0}};
			acc2    <= {W{1'b0}};
			acc3    <= {W{1'b0}};
			c2_d    <= 1'b0;
			c3_d    <= 1'b0;
			c3_dd   <= 1'b0;
		end else if (step_en) begin
			acc1    <= next_acc1;
			acc2    <= next_acc2;
			acc3    <= next_acc3;
			c2_d    <= c2;
			c3_d    <= c3;
			c3_dd   <= c3_d;
			sdm_out <= next_sdm_out;
			if (dither_en) begin
				lfsr <= {lfsr[0] ^ lfsr[2], lfsr[20:1]};
			end
		end
	end

endmodule // flsdm_sdm

`default_nettype wire

// File: flsdm_top.v
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "flsdm_consts.vh"

module flsdm_top #(
	parameter       W       = 12,
	parameter [7:0] PFD_DIV = `FLSDM_PFD_DIV
) (
	input  wire               aclk,
	input  wire               aresetn,
	input  wire [7:0]         s_axi_awaddr,
	input  wire [2:0]         s_axi_awprot,
	input  wire               s_axi_awvalid,
	output wire               s_axi_awready,
	input  wire [31:0]        s_axi_wdata,
	input  wire [3:0]         s_axi_wstrb,
	input  wire               s_axi_wvalid,
	output wire               s_axi_wready,
	output reg  [1:0]         s_axi_bresp,
	output reg                s_axi_bvalid,
	input  wire               s_axi_bready,
	input  wire [7:0]         s_axi_araddr,
	input  wire [2:0]         s_axi_arprot,
	input  wire               s_axi_arvalid,
	output wire               s_axi_arready,
	output reg  [31:0]        s_axi_rdata,
	output reg  [1:0]         s_axi_rresp,
	output reg                s_axi_rvalid,
	input  wire               s_axi_rready,
	output wire               multiplexed_output_pin_o,
	output reg                multiplexed_output_pin_oe,
	output reg  [7:0]         charge_pump_current,
	output reg                wide_bandwidth,
	output reg  signed [3:0]  sigma_delta_modulator_out,
	output wire               phase_compare_tick
);

	reg  [7:0]          aw_addr;
	reg                 aw_held;
	reg  [23:0]         w_data;
	reg  [3:0]          w_strb;
	reg                 w_held;
	reg  [23:0]         img_refdiv;
	reg  [23:0]         img_ndiv;
	reg  [23:0]         img_ctrl;
	reg  [23:0]         img_noise;
	reg  [W-1:0]        fraction_modulus;
	reg  [W-1:0]        timer_count;
	reg  [W-1:0]        fraction_value;
	reg  [2:0]          mux_select;
	reg  [3:0]          cp_setting;
	reg  [1:0]          noise_mode;
	reg  [W-1:0]        countdown;
	reg  [7:0]          pfd_cnt;
	reg                 pfd_tick;
	reg  [23:0]         merged;
	reg  [23:0]         base_img;
	reg  [1:0]          next_bresp;
	reg  [31:0]         next_rdata;
	reg  [1:0]          next_rresp;
	wire                do_write;
	wire                do_read;
	wire                dither_en;
	wire                switch_sel;
	wire [W-1:0]        field_val;
	wire                fl_start;
	wire signed [3:0]   sdm_raw;
	integer             i;

	// ==========================================================
	// comparison-rate enable divider
	assign phase_compare_tick = pfd_tick;

	always @(posedge aclk) begin
		if (!aresetn) begin
			pfd_cnt  <= 8'h00;
			pfd_tick <= 1'b0;
		end else if (pfd_cnt >= PFD_DIV - 8'h01) begin
			pfd_cnt  <= 8'h00;
			pfd_tick <= 1'b1;
		end else begin
			pfd_cnt  <= pfd_cnt + 8'h01;
			pfd_tick <= 1'b0;
		end
	end

	// ==========================================================
	// write channel capture
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign do_write      = aw_held && w_held && !s_axi_bvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_addr <= 8'h00;
			aw_held <= 1'b0;
			w_data  <= `FLSDM_RST_WORD;
			w_strb  <= 4'h0;
			w_held  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
				aw_held <= 1'b1;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data  <= s_axi_wdata[23:0];
				w_strb  <= s_axi_wstrb;
				w_held  <= 1'b1;
			end else if (do_write) begin
				w_held  <= 1'b0;
			end
		end
	end

	// ==========================================================
	// write decode with byte-lane merge onto the word image
	always @* begin
		case (aw_addr)
			`FLSDM_OFF_REFDIV: base_img = img_refdiv;
			`FLSDM_OFF_NDIV:   base_img = img_ndiv;
			`FLSDM_OFF_CTRL:   base_img = img_ctrl;
			`FLSDM_OFF_NOISE:  base_img = img_noise;
			default:           base_img = `FLSDM_RST_WORD;
		endcase
		for (i = 0; i < 3; i = i + 1) begin
			merged[i*8 +: 8] = w_strb[i] ? w_data[i*8 +: 8] : base_img[i*8 +: 8];
		end
	end

	assign field_val = merged[`FLSDM_MODFLD_HI:`FLSDM_MODFLD_LO];

	always @* begin
		case (aw_addr)
			`FLSDM_OFF_REFDIV: begin
				if (!merged[`FLSDM_LOADCTL_BIT] && field_val < `FLSDM_MOD_MIN) begin
					next_bresp = `FLSDM_RESP_SLVERR;
				end else begin
					next_bresp = `FLSDM_RESP_OKAY;
				end
			end
			`FLSDM_OFF_NDIV:   next_bresp = `FLSDM_RESP_OKAY;
			`FLSDM_OFF_CTRL:   next_bresp = `FLSDM_RESP_OKAY;
			`FLSDM_OFF_NOISE:  next_bresp = `FLSDM_RESP_OKAY;
			default:           next_bresp = `FLSDM_RESP_SLVERR;
		endcase
	end

	assign fl_start = do_write && (aw_addr == `FLSDM_OFF_NDIV) && merged[`FLSDM_FLFLAG_BIT];

	always @(posedge aclk) begin
		if (!aresetn) begin
			img_refdiv       <= `FLSDM_RST_WORD;
			img_ndiv         <= `FLSDM_RST_WORD;
			img_ctrl         <= `FLSDM_RST_WORD;
			img_noise        <= `FLSDM_RST_WORD;
			fraction_modulus <= `FLSDM_RST_MOD;
			timer_count      <= {W{1'b0}};
			fraction_value   <= {W{1'b0}};
			mux_select       <= 3'b000;
			cp_setting       <= 4'h0;
			noise_mode       <= `FLSDM_NSMODE_SPUR;
			s_axi_bvalid     <= 1'b0;
			s_axi_bresp      <= `FLSDM_RESP_OKAY;
		end else begin
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= next_bresp;
				case (aw_addr)
					`FLSDM_OFF_REFDIV: begin
						if (merged[`FLSDM_LOADCTL_BIT]) begin
							timer_count <= field_val;
							img_refdiv  <= merged;
						end else if (field_val >= `FLSDM_MOD_MIN) begin
							fraction_modulus <= field_val;
							mux_select       <= merged[`FLSDM_MUXSEL_HI:`FLSDM_MUXSEL_LO];
							img_refdiv       <= merged;
						end
					end
					`FLSDM_OFF_NDIV: begin
						img_ndiv       <= merged;
						fraction_value <= merged[`FLSDM_FRACFLD_HI:`FLSDM_FRACFLD_LO];
					end
					`FLSDM_OFF_CTRL: begin
						img_ctrl   <= merged;
						cp_setting <= merged[`FLSDM_CPCUR_HI:`FLSDM_CPCUR_LO];
					end
					`FLSDM_OFF_NOISE: begin
						img_noise  <= merged;
						noise_mode <= merged[`FLSDM_NSMODE_HI:`FLSDM_NSMODE_LO];
					end
					default: begin
						img_noise <= img_noise;
					end
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// fast-lock countdown
	always @(posedge aclk) begin
		if (!aresetn) begin
			countdown <= {W{1'b0}};
		end else if (fl_start) begin
			countdown <= timer_count;
		end else if (pfd_tick && countdown != {W{1'b0}}) begin
			countdown <= countdown - {{(W-1){1'b0}}, 1'b1};
		end
	end

	assign switch_sel = (mux_select == `FLSDM_MUXSEL_FLSW);

	always @(posedge aclk) begin
		if (!aresetn) begin
			wide_bandwidth            <= 1'b0;
			multiplexed_output_pin_oe <= 1'b0;
			charge_pump_current       <= 8'h00;
		end else begin
			wide_bandwidth            <= (countdown != {W{1'b0}});
			multiplexed_output_pin_oe <= (countdown != {W{1'b0}}) && switch_sel;
			if (countdown != {W{1'b0}}) begin
				charge_pump_current <= {cp_setting, 4'h0};
			end else begin
				charge_pump_current <= {4'h0, cp_setting};
			end
		end
	end

	assign multiplexed_output_pin_o = 1'b0;

	// ==========================================================
	// modulator
	assign dither_en = (noise_mode == `FLSDM_NSMODE_SPUR);

	flsdm_sdm #(
		.W (W)
	) u_sdm (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.step_en   (pfd_tick),
		.modulus   (fraction_modulus),
		.fraction  (fraction_value),
		.dither_en (dither_en),
		.sdm_out   (sdm_raw)
	);

	always @(posedge aclk) begin
		if (!aresetn) begin
			sigma_delta_modulator_out <= 4'sh0;
		end else begin
			sigma_delta_modulator_out <= sdm_raw;
		end
	end

	// ==========================================================
	// read channel
	assign s_axi_arready = !s_axi_rvalid;
	assign do_read       = s_axi_arvalid && s_axi_arready;

	always @* begin
		next_rresp = `FLSDM_RESP_OKAY;
		case (s_axi_araddr)
			`FLSDM_OFF_REFDIV: next_rdata = {8'h00, img_refdiv};
			`FLSDM_OFF_NDIV:   next_rdata = {8'h00, img_ndiv};
			`FLSDM_OFF_CTRL:   next_rdata = {8'h00, img_ctrl};
			`FLSDM_OFF_NOISE:  next_rdata = {8'h00, img_noise};
			`FLSDM_OFF_STATUS: next_rdata = {13'h0000, dither_en, multiplexed_output_pin_oe,
				wide_bandwidth, 4'h0, countdown};
			`FLSDM_OFF_STORED: next_rdata = {4'h0, timer_count, 4'h0, fraction_modulus};
			default: begin
				next_rdata = 32'h00000000;
				next_rresp = `FLSDM_RESP_SLVERR;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `FLSDM_RESP_OKAY;
		end else if (do_read) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= next_rdata;
			s_axi_rresp  <= next_rresp;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // flsdm_top

`default_nettype wire

// File: flsdm_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// fast-lock and modulator port checks
module flsdm_monitor #(
	parameter int PFD_DIV = 3
) (
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic              s_axi_bvalid,
	input wire logic              multiplexed_output_pin_o,
	input wire logic              multiplexed_output_pin_oe,
	input wire logic [7:0]        charge_pump_current,
	input wire logic              wide_bandwidth,
	input wire logic signed [3:0] sigma_delta_modulator_out,
	input wire logic              phase_compare_tick
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_TICK_PULSE: assert property (phase_compare_tick |=> !phase_compare_tick)
		else $error("comparison tick wider than one cycle");
	AST_TICK_PERIOD: assert property (phase_compare_tick |-> ##PFD_DIV phase_compare_tick)
		else $error("comparison tick period wrong");
	AST_SDM_RANGE: assert property (sigma_delta_modulator_out >= -3 && sigma_delta_modulator_out <= 4)
		else $error("modulator output out of range");
	AST_SDM_STEP: assert property (!$stable(sigma_delta_modulator_out) |->
		$past(phase_compare_tick) || $past(phase_compare_tick, 2))
		else $error("modulator output moved off a comparison step");
	AST_WB_START: assert property ($rose(wide_bandwidth) |-> $past(s_axi_bvalid))
		else $error("wide bandwidth began without a write");
	AST_WB_END: assert property ($fell(wide_bandwidth) |->
		$past(phase_compare_tick) || $past(phase_compare_tick, 2))
		else $error("wide bandwidth ended off a comparison step");
	AST_BOOST_ON: assert property ($rose(wide_bandwidth) |->
		charge_pump_current == {$past(charge_pump_current[3:0]), 4'h0})
		else $error("pump current not raised sixteen times");
	AST_BOOST_OFF: assert property ($fell(wide_bandwidth) |->
		charge_pump_current == {4'h0, $past(charge_pump_current[7:4])})
		else $error("pump current not restored");
	AST_PIN_GND: assert property (multiplexed_output_pin_oe |-> wide_bandwidth && !multiplexed_output_pin_o)
		else $error("output switch closed outside the interval");
	AST_PIN_START: assert property ($rose(multiplexed_output_pin_oe) |-> $rose(wide_bandwidth))
		else $error("output switch closed late or early");
	cover property ($rose(wide_bandwidth));
	cover property ($fell(wide_bandwidth));
	cover property ($rose(multiplexed_output_pin_oe));
endmodule // flsdm_monitor

bind flsdm_top flsdm_monitor #(.PFD_DIV(PFD_DIV)) mon (.aclk(aclk), .aresetn(aresetn),
	.s_axi_bvalid(s_axi_bvalid), .multiplexed_output_pin_o(multiplexed_output_pin_o),
	.multiplexed_output_pin_oe(multiplexed_output_pin_oe), .charge_pump_current(charge_pump_current),
	.wide_bandwidth(wide_bandwidth), .sigma_delta_modulator_out(sigma_delta_modulator_out),
	.phase_compare_tick(phase_compare_tick));
`default_nettype wire

// File: flsdm_host.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// host controller writing configuration words
module flsdm_host (
	input  wire logic        aclk,
	output var  logic [7:0]  awaddr,
	output var  logic        awvalid,
	input  wire logic        awready,
	output var  logic [31:0] wdata,
	output var  logic        wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output var  logic        bready,
	output var  logic [7:0]  araddr,
	output var  logic        arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output var  logic        rready
);
	initial begin
		{awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
		logic ad;
		logic dd;
		ad = 0;
		dd = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(ad && dd)) begin
			@(posedge aclk);
			if (!ad && awready) begin
				awvalid <= 0;
				ad = 1;
			end
			if (!dd && wready) begin
				wvalid <= 0;
				dd = 1;
			end
		end
		@(posedge aclk);
		while (!bvalid) @(posedge aclk);
		r = bresp;
		bready <= 0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		@(posedge aclk);
		while (!arready) @(posedge aclk);
		arvalid <= 0;
		while (!rvalid) @(posedge aclk);
		v = rdata;
		r = rresp;
		rready <= 0;
	endtask
endmodule // flsdm_host
`default_nettype wire

// File: tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic              aclk = 0;
	logic              aresetn = 0;
	logic [7:0]        awaddr, araddr, cp;
	logic [31:0]       wdata, rdata, d;
	logic [1:0]        bresp, rresp, r;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready, pin_o, pin_oe, wb, tick;
	logic signed [3:0] sdo;
	int                miscompares = 0, checked = 0, seed = 32'h125d7220;
	int                m_modu = 2, m_tmr = 0, m_dith = 1, v;
	int                mv[4] = '{0, 1, 4095, 2};
	always #12.5 aclk = ~aclk;
	flsdm_top #(.W(12), .PFD_DIV(8'h03)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.multiplexed_output_pin_o(pin_o), .multiplexed_output_pin_oe(pin_oe), .charge_pump_current(cp),
		.wide_bandwidth(wb), .sigma_delta_modulator_out(sdo), .phase_compare_tick(tick));
	flsdm_host h (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	// ==========================================================
	// model and checks
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		logic [1:0] e;
		e = 2'b00;
		if (a == 8'h00 && x[23])
			m_tmr = x[13:2];
		else if (a == 8'h00 && x[13:2] < 2)
			e = 2'b10;
		else if (a == 8'h00)
			m_modu = x[13:2];
		else if (a == 8'h0c)
			m_dith = (x[3:2] == 2'b00);
		else if (a > 8'h0c)
			e = 2'b10;
		h.wr(a, x, r);
		chk("bresp", e, r);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		h.rd(a, d, r);
		chk("rdata", e, d);
		chk("rresp", (a > 8'h14) ? 2'b10 : 2'b00, r);
	endtask
	function automatic logic [31:0] st();
		return {4'h0, m_tmr[11:0], 4'h0, m_modu[11:0]};
	endfunction
	task automatic fl(input int t, input logic sel);
		int n;
		int k;
		n = 0;
		k = 0;
		wr(8'h04, 32'h800000);
		while (!wb && k < 20) begin
			@(posedge aclk);
			k++;
		end
		chk("wb_on", t != 0, wb);
		chk("pin_oe", sel && t != 0, pin_oe);
		chk("pin_o", 1'b0, pin_o);
		chk("cp_fast", (t != 0) ? 8'h30 : 8'h03, cp);
		k = 0;
		while (wb && k < 3 * t + 12) begin
			@(posedge aclk);
			n += tick;
			k++;
		end
		if (t != 0)
			chk("fl_len", 1, n >= t - 1 && n <= t + 1);
		chk("cp_back", 8'h03, cp);
		chk("pin_off", 0, pin_oe);
	endtask
	task automatic per(input int md, input logic [31:0] ns);
		logic signed [3:0] q[$];
		int L;
		int mis;
		mis = 0;
		wr(8'h0c, ns);
		wr(8'h00, md << 2);
		wr(8'h04, 32'h4);
		L = (md % 6 == 0) ? 6 * md : (md % 2 == 0) ? 2 * md : (md % 3 == 0) ? 3 * md : md;
		while (q.size() < 3 * L) begin
			@(posedge aclk);
			if (tick)
				q.push_back(sdo);
		end
		for (int i = L; i < 2 * L; i++)
			mis += (q[i] !== q[i + L]);
		chk("repeat", m_dith, mis != 0);
	endtask
	task automatic complete_run;
		$display("counts: checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ==========================================================
	// scenarios
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		rd(8'h10, 32'h40000);
		rd(8'h14, st());
		wr(8'h00, 32'h800000 | (5 << 2));
		rd(8'h14, st());
		wr(8'h0c, 32'h4);
		wr(8'h08, 32'h180);
		wr(8'h00, 32'h600000 | (50 << 2));
		rd(8'h14, st());
		fl(5, 1);
		fl(5, 1);
		wr(8'h00, 32'h800000);
		fl(0, 1);
		$display("test fast lock done");
		repeat (4) begin
			v = $unsigned($random(seed)) % 9 + 1;
			wr(8'h00, 32'h800000 | (v << 2));
			fl(v, 1);
		end
		wr(8'h00, 50 << 2);
		fl(v, 0);
		$display("test timer and selector done");
		foreach (mv[i]) begin
			wr(8'h00, mv[i] << 2);
			rd(8'h14, st());
		end
		repeat (6) begin
			v = 2 + $unsigned($random(seed)) % 4094;
			wr(8'h00, v << 2);
			rd(8'h14, st());
		end
		wr(8'h18, 0);
		wr(8'h10, 0);
		rd(8'h18, 0);
		for (int m = 0; m < 4; m++) begin
			wr(8'h0c, m << 2);
			rd(8'h10, {13'h0, m_dith[0], 18'h0});
		end
		$display("test registers done");
		per(10, 32'h4);
		per(9, 32'h8);
		per(12, 32'hc);
		per(7, 32'h4);
		per(50, 32'hc);
		per(50, 32'h0);
		$display("test modulator done");
		complete_run;
	end
	initial begin
		repeat (60000) @(posedge aclk);
		miscompares++;
		complete_run;
	end
endmodule // tb
`default_nettype wire
